// ==== core/epc_core.sv ====
// encoder position comparator core
`timescale 1ns/10ps
module epc_core #(
   parameter int MS_COUNT = epc_pkg::MS_CYC
) (
   input  wire logic                     sys_clk,
   input  wire logic                     reset_n,
   input  wire epc_pkg::epc_mode_type    mode,
   input  wire logic                     reverse_dir,
   input  wire logic [15:0]              position_offset,
   input  wire logic                     fast_filter,
   input  wire logic [15:0]              quad_max,
   input  wire logic [15:0]              preload_position,
   input  wire logic [15:0]              home_position,
   input  wire epc_pkg::epc_cmp_cfg_type cmp_cfg [epc_pkg::NUM_CMP],
   input  wire logic [3:0]               strobe_rising,
   input  wire epc_pkg::epc_cmd_type     cmd,
   input  wire logic                     bad_data_cmd,
   input  wire logic [9:0]               gray_in,
   input  wire logic                     quad_a,
   input  wire logic                     quad_b,
   input  wire logic                     marker_pin,
   input  wire logic                     preload_pin,
   input  wire logic                     home_switch_pin,
   input  wire logic                     general_input_six,
   input  wire logic                     general_input_seven,
   input  wire logic                     general_input_eight,
   input  wire logic [3:0]               point_in,
   output logic [31:0]                   status_bit_image,
   output logic [3:0]                    point_out,
   output logic [3:0]                    point_out_en,
   output logic [3:0]                    strobe_capture,
   output logic [15:0]                   position
);

   // ----------------------------------------------------------------
   // input synchronisers: three stages, change when stages 2,3 agree
   // ----------------------------------------------------------------
   localparam int NS = 22;
   logic [NS-1:0] raw, s1_ff, s2_ff, s3_ff, clean_ff, nxt_clean;
   assign raw = {point_in, general_input_eight, general_input_seven, general_input_six,
                 home_switch_pin, preload_pin, marker_pin, quad_b, quad_a, gray_in};
   assign nxt_clean = (s2_ff == s3_ff) ? s3_ff : clean_ff;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_ff <= '0; s2_ff <= '0; s3_ff <= '0; clean_ff <= '0;
      end else begin
         s1_ff <= raw; s2_ff <= s1_ff; s3_ff <= s2_ff; clean_ff <= nxt_clean;
      end
   end

   // ----------------------------------------------------------------
   // quadrature filter: a, b, marker, preload must hold stable
   // ----------------------------------------------------------------
   logic [3:0]  f_in, filt_ff;
   logic [3:0][9:0] fcnt_ff;
   logic [9:0]  filt_len;
   assign f_in     = clean_ff[13:10];
   assign filt_len = fast_filter ? 10'(epc_pkg::FILT_FAST_CYC)
                                 : 10'(epc_pkg::FILT_SLOW_CYC);
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         filt_ff <= '0; fcnt_ff <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (f_in[i] == filt_ff[i]) fcnt_ff[i] <= '0;
            else if (fcnt_ff[i] >= filt_len - 10'h001) begin
               filt_ff[i] <= f_in[i]; fcnt_ff[i] <= '0;
            end else fcnt_ff[i] <= fcnt_ff[i] + 10'h001;
         end
      end
   end

   // ----------------------------------------------------------------
   // quadrature decode, counter, preload and home
   // ----------------------------------------------------------------
   logic [1:0]  ab_ff;
   logic        mark_ff, pre_ff, homing_ff, home_found_ff, pre_latch_ff, home_cmd_ff;
   logic [15:0] qcnt_ff, nxt_qcnt, qmax;
   logic        step, up_raw, up, marker_edge, pre_edge, home_hit, pin_preload;
   assign qmax   = (quad_max < epc_pkg::QUAD_MAX_LOW) ? epc_pkg::QUAD_MAX_LOW
                 : (quad_max > epc_pkg::QUAD_MAX_HIGH) ? epc_pkg::QUAD_MAX_HIGH : quad_max;
   assign step   = (filt_ff[1:0] != ab_ff) && ((filt_ff[1:0] ^ ab_ff) != 2'h3);
   assign up_raw = filt_ff[0] ^ ab_ff[1];
   assign up     = up_raw ^ reverse_dir;
   assign marker_edge = filt_ff[2] & ~mark_ff;
   assign pre_edge    = filt_ff[3] & ~pre_ff;
   assign pin_preload = pre_edge & ~pre_latch_ff;
   assign home_hit    = homing_ff & clean_ff[14] & marker_edge;
   always_comb begin
      nxt_qcnt = qcnt_ff;
      if (home_hit) nxt_qcnt = home_position;
      else if (pin_preload || cmd.preload) nxt_qcnt = preload_position;
      else if (step && up) nxt_qcnt = (qcnt_ff >= qmax) ? 16'h0000 : qcnt_ff + 16'h0001;
      else if (step) nxt_qcnt = (qcnt_ff == 16'h0000) ? qmax : qcnt_ff - 16'h0001;
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ab_ff <= '0; mark_ff <= 1'b0; pre_ff <= 1'b0; qcnt_ff <= '0;
         homing_ff <= 1'b0; home_found_ff <= 1'b0; pre_latch_ff <= 1'b0;
         home_cmd_ff <= 1'b0;
      end else begin
         ab_ff <= filt_ff[1:0]; mark_ff <= filt_ff[2]; pre_ff <= filt_ff[3];
         qcnt_ff <= nxt_qcnt;
         home_cmd_ff <= cmd.home_start;
         if (home_hit) homing_ff <= 1'b0;
         else if (cmd.home_start & ~home_cmd_ff) homing_ff <= 1'b1;
         if (home_hit) home_found_ff <= 1'b1;
         else if (cmd.home_start & ~home_cmd_ff) home_found_ff <= 1'b0;
         if (pin_preload) pre_latch_ff <= 1'b1;
         else if (cmd.reset_preload) pre_latch_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // gray decode and absolute position
   // ----------------------------------------------------------------
   logic [9:0]  gw, bin;
   logic [15:0] enc_max, raw_pos, dir_pos, sum, pos;
   logic        quad;
   assign quad = (mode == epc_pkg::QUADRATURE_MODE);
   always_comb begin
      unique case (mode)
         epc_pkg::GRAY_8BIT_MODE:  gw = {2'b00, clean_ff[7:0]};
         epc_pkg::GRAY_10BIT_MODE: gw = clean_ff[9:0];
         default:                  gw = {1'b0, clean_ff[8:0]};
      endcase
      bin[9] = gw[9];
      for (int i = 8; i >= 0; i--) bin[i] = bin[i+1] ^ gw[i];
   end
   assign enc_max = quad ? qmax
                  : (mode == epc_pkg::GRAY_EXCESS_MODE) ? epc_pkg::EXCESS_TOP
                  : (mode == epc_pkg::GRAY_9BIT_MODE) ? epc_pkg::MAX_9BIT
                  : (mode == epc_pkg::GRAY_10BIT_MODE) ? epc_pkg::MAX_10BIT : epc_pkg::MAX_8BIT;
   assign raw_pos = quad ? qcnt_ff
                  : (mode == epc_pkg::GRAY_EXCESS_MODE) ? {6'h00, bin} - epc_pkg::EXCESS_BIAS
                  : {6'h00, bin};
   assign dir_pos = (reverse_dir && !quad) ? enc_max - raw_pos : raw_pos;
   assign sum     = 16'(dir_pos + position_offset);
   assign pos     = (sum > enc_max) ? 16'(sum - enc_max - 16'h0001) : sum;

   // ----------------------------------------------------------------
   // range comparators
   // ----------------------------------------------------------------
   logic [15:0] pos_ff, cmp_ff, tmr_out_ff;
   logic [15:0][15:0] tms_ff;
   logic [15:0][31:0] tcyc_ff;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pos_ff <= '0; cmp_ff <= '0; tmr_out_ff <= '0; tms_ff <= '0; tcyc_ff <= '0;
      end else begin
         pos_ff <= pos;
         for (int i = 0; i < epc_pkg::NUM_CMP; i++) begin
            if (pos == cmp_cfg[i].on_preset && pos != pos_ff) begin
               cmp_ff[i] <= 1'b1;
               tms_ff[i] <= cmp_cfg[i].timer1_ms;
               tcyc_ff[i] <= '0;
               tmr_out_ff[i] <= (cmp_cfg[i].timer1_ms != 16'h0000);
            end else if (pos == cmp_cfg[i].off_preset && pos != pos_ff) begin
               cmp_ff[i] <= 1'b0;
               tms_ff[i] <= cmp_cfg[i].timer2_ms;
               tcyc_ff[i] <= '0;
               tmr_out_ff[i] <= (cmp_cfg[i].timer2_ms != 16'h0000);
            end else if (tmr_out_ff[i]) begin
               if (tcyc_ff[i] >= 32'(MS_COUNT - 1)) begin
                  tcyc_ff[i] <= '0;
                  tms_ff[i] <= tms_ff[i] - 16'h0001;
                  if (tms_ff[i] <= 16'h0001) tmr_out_ff[i] <= 1'b0;
               end else tcyc_ff[i] <= tcyc_ff[i] + 32'h1;
            end
         end
      end
   end
   logic [15:0] cmp_state;
   always_comb
      for (int i = 0; i < epc_pkg::NUM_CMP; i++)
         cmp_state[i] = cmp_cfg[i].timer_mode ? tmr_out_ff[i] : cmp_ff[i];

   // ----------------------------------------------------------------
   // points 9..12: outputs, strobes, latches
   // ----------------------------------------------------------------
   logic [3:0] claimed, pin_ff, latch_ff, edge_hit, cap;
   assign claimed = (mode == epc_pkg::GRAY_10BIT_MODE) ? 4'h3
                  : (mode == epc_pkg::GRAY_EXCESS_MODE || mode == epc_pkg::GRAY_9BIT_MODE)
                    ? 4'h1 : 4'h0;
   assign edge_hit = (clean_ff[21:18] ^ pin_ff) & ~(clean_ff[21:18] ^ strobe_rising);
   assign cap      = edge_hit & ~claimed & ~latch_ff;
   logic err_ff, clr_ff, ready_ff;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_ff <= '0; latch_ff <= '0; point_out <= '0; point_out_en <= '0;
         strobe_capture <= '0; position <= '0; err_ff <= 1'b0; clr_ff <= 1'b0;
         ready_ff <= 1'b0; status_bit_image <= '0;
      end else begin
         pin_ff <= clean_ff[21:18];
         latch_ff <= cap | (latch_ff & ~cmd.reset_strobe);
         strobe_capture <= cap;
         point_out <= cmp_state[7:4] & ~claimed;
         point_out_en <= '0;
         position <= pos;
         ready_ff <= 1'b1;
         clr_ff <= cmd.clear_error;
         if (bad_data_cmd) err_ff <= 1'b1;
         else if (cmd.clear_error != clr_ff) err_ff <= 1'b0;
         status_bit_image <= {err_ff, ready_ff,
            quad ? {clean_ff[17:15], clean_ff[14], pre_latch_ff, home_found_ff}
                 : 6'h00,
            latch_ff, clean_ff[21:18],
            cmp_state};
      end
   end

endmodule

// ==== pkg/epc_pkg.sv ====
// constants and types of the encoder position comparator
//
// Function
// - gray modes take 8, 9, 10 bit words
// - excess gray mode decodes excess-76 to 0..359
// - 360/512 modes claim point nine, drop output five
// - 1024 mode claims points nine, ten, outputs five, six
// - reverse direction inverts counting sense
// - position offset added, resets to zero
// - quadrature inputs filtered 20 us or 2 us
// - quadrature counter rolls at configured maximum
// - preload pin or command loads preload position
// - marker during home cycle loads home position
// - preset mode holds output between presets
// - timer one pulse at on preset, zero none
// - timer two pulse at off preset, zero none
// - output on at on preset, off at off
// - status and command image exchanged every scan
// - comparators 1..16 at status bits 0..15
// - points 9..12 at 16..19, latches 20..23
// - quadrature flags and inputs at bits 24..29
// - ready at bit 30, error at 31
// - latched strobe locks out until reset command
// - preload latch locks pin until reset command
// - error holds until clear-error bit toggles
// - home switch closed then marker sets home found
package epc_pkg;

   // ----------------------------------------------------------------
   // modes and layout
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      GRAY_8BIT_MODE, GRAY_EXCESS_MODE, GRAY_9BIT_MODE, GRAY_10BIT_MODE, QUADRATURE_MODE
   } epc_mode_type;

   localparam int NUM_CMP          = 16;
   localparam logic [15:0] EXCESS_BIAS    = 16'h004c; // 76
   localparam logic [15:0] EXCESS_TOP     = 16'h0167; // 359
   localparam logic [15:0] MAX_8BIT       = 16'h00ff;
   localparam logic [15:0] MAX_9BIT       = 16'h01ff;
   localparam logic [15:0] MAX_10BIT      = 16'h03ff;
   localparam logic [15:0] QUAD_MAX_RESET = 16'h00ff; // default 255
   localparam logic [15:0] QUAD_MAX_LOW   = 16'h000a; // 10
   localparam logic [15:0] QUAD_MAX_HIGH  = 16'hfde7; // 64999
   localparam logic [15:0] OFFSET_RESET   = 16'h0000;
   localparam logic [15:0] OFF_PRE_RESET  = 16'h0000;
   localparam logic [15:0] TIMER_RESET    = 16'h0000;

   // status bit positions
   localparam int ST_CMP_LSB   = 0;
   localparam int ST_IN_LSB    = 16;
   localparam int ST_LATCH_LSB = 20;
   localparam int ST_HOME      = 24;
   localparam int ST_PRELATCH  = 25;
   localparam int ST_HOMESW    = 26;
   localparam int ST_GEN_LSB   = 27;
   localparam int ST_READY     = 30;
   localparam int ST_ERROR     = 31;
   localparam logic [1:0] STATUS_BIT_IMAGE_OFS = 2'h0;

   // timing
   localparam int CLK_HZ        = 50_000_000;
   localparam int FILT_SLOW_NS  = 20_000;
   localparam int FILT_FAST_NS  = 2_000;
   localparam int FILT_SLOW_CYC = FILT_SLOW_NS / (1_000_000_000 / CLK_HZ);
   localparam int FILT_FAST_CYC = FILT_FAST_NS / (1_000_000_000 / CLK_HZ);
   localparam int MS_CYC        = CLK_HZ / 1000;

   // per-comparator setup
   typedef struct packed {
      logic        timer_mode;
      logic [15:0] on_preset;
      logic [15:0] off_preset;
      logic [15:0] timer1_ms;
      logic [15:0] timer2_ms;
   } epc_cmp_cfg_type;

   // command bits from host
   typedef struct packed {
      logic [3:0] reset_strobe;
      logic       reset_preload;
      logic       preload;
      logic       home_start;
      logic       clear_error;
   } epc_cmd_type;

endpackage

// ==== dv/epc_core_checker.sv ====
// port assertions for the encoder position comparator
`timescale 1ns/10ps
module epc_core_checker #(
   parameter int MS_COUNT = 50000
) (
   input wire logic                  sys_clk,
   input wire logic                  reset_n,
   input wire epc_pkg::epc_mode_type mode,
   input wire logic [15:0]           quad_max,
   input wire epc_pkg::epc_cmd_type  cmd,
   input wire logic                  bad_data_cmd,
   input wire logic [31:0]           status_bit_image,
   input wire logic [3:0]            point_out_en,
   input wire logic [3:0]            strobe_capture,
   input wire logic [15:0]           position
);
   // ----
   // edges since reset release, saturating at three
   // ----
   logic [1:0] rel_ff;
   logic [1:0] nxt_rel;
   assign nxt_rel = rel_ff + {1'b0, rel_ff != 2'h3};
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) rel_ff <= 2'h0;
      else rel_ff <= nxt_rel;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_ready_bit: assert property (rel_ff[1] |-> status_bit_image[30])
      else $error("ready bit low after reset");
   a_error_set: assert property (bad_data_cmd |-> ##[1:4] status_bit_image[31])
      else $error("bad data did not raise error");
   a_error_hold: assert property (
      (status_bit_image[31] && $stable(cmd.clear_error))[*5] |=> status_bit_image[31])
      else $error("error dropped without clear toggle");
   a_strobe_lock: assert property (
      (status_bit_image[23] && !cmd.reset_strobe[3])[*3] |-> !strobe_capture[3])
      else $error("strobe captured while latched");
   a_claim_ten: assert property (
      (mode == epc_pkg::GRAY_10BIT_MODE)[*8] |-> strobe_capture[1:0] == 2'h0)
      else $error("claimed point captured a strobe");
   a_out_en_off: assert property (point_out_en == 4'h0)
      else $error("claimed point driven");
   a_range_8bit: assert property (
      (mode == epc_pkg::GRAY_8BIT_MODE)[*8] |-> position <= 16'h00ff)
      else $error("position above 8 bit range");
   a_quad_range: assert property (
      (mode == epc_pkg::QUADRATURE_MODE && $stable(quad_max))[*8] |-> position <= quad_max)
      else $error("position above quadrature maximum");
   c_strobe: cover property (strobe_capture[3]);
   c_home: cover property (status_bit_image[24]);
   c_error: cover property (status_bit_image[31]);
endmodule

bind epc_core epc_core_checker #(.MS_COUNT(MS_COUNT)) i_epc_core_checker (.sys_clk, .reset_n,
   .mode, .quad_max, .cmd, .bad_data_cmd, .status_bit_image, .point_out_en, .strobe_capture,
   .position);

// ==== dv/epc_quad_model.sv ====
// quadrature encoder stepped one transition at a time
`timescale 1ns/10ps
module epc_quad_model (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic step,
   input  wire logic dir,
   output logic      quad_a,
   output logic      quad_b
);
   logic [1:0] phase_ff;
   // a leads b while dir is high
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) phase_ff <= 2'h0;
      else if (step) phase_ff <= dir ? phase_ff + 2'h1 : phase_ff - 2'h1;
   end
   assign quad_a = phase_ff[0] ^ phase_ff[1];
   assign quad_b = phase_ff[1];
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the encoder position comparator
`timescale 1ns/10ps
module tb;
   logic                     sys_clk = 1'b0, reset_n = 1'b0, reverse_dir = 1'b0;
   logic                     fast_filter = 1'b1, bad_data_cmd = 1'b0, marker_pin = 1'b0;
   logic                     preload_pin = 1'b0, home_switch_pin = 1'b0, step = 1'b0;
   logic                     dir = 1'b1, quad_a, quad_b;
   epc_pkg::epc_mode_type    mode = epc_pkg::QUADRATURE_MODE;
   logic [15:0]              position_offset = 16'h0000, quad_max = 16'h000a, position;
   logic [15:0]              preload_position = 16'h0007, home_position = 16'h0003;
   epc_pkg::epc_cmp_cfg_type cmp_cfg [epc_pkg::NUM_CMP];
   epc_pkg::epc_cmd_type     cmd = 8'h00;
   logic [9:0]               gray_in = 10'h000;
   logic [2:0]               gen_in = 3'h5;
   logic [3:0]               point_in = 4'h0, point_out_en, strobe_capture, point_out;
   logic [31:0]              status_bit_image;
   int                       num_errors = 0, samples_checked = 0, cycles = 0, caps = 0;

   epc_core #(.MS_COUNT(10)) i_epc_core (.sys_clk, .reset_n, .mode, .reverse_dir,
      .position_offset, .fast_filter, .quad_max, .preload_position, .home_position,
      .cmp_cfg, .strobe_rising(4'hf), .cmd, .bad_data_cmd, .gray_in, .quad_a, .quad_b,
      .marker_pin, .preload_pin, .home_switch_pin, .general_input_six(gen_in[0]),
      .general_input_seven(gen_in[1]), .general_input_eight(gen_in[2]), .point_in,
      .status_bit_image, .point_out, .point_out_en, .strobe_capture, .position);
   epc_quad_model i_epc_quad_model (.sys_clk, .reset_n, .step, .dir, .quad_a, .quad_b);

   // ----
   // clock, hang limit, capture counter
   // ----
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (strobe_capture[3] === 1'b1) caps <= caps + 1;
      if (cycles == 20000) begin
         num_errors++;
         conclude();
      end
   end

   task automatic conclude;
      $display("checked %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic steps(input int n, input logic d);
      repeat (n) begin
         @(posedge sys_clk) {step, dir} <= {1'b1, d};
         @(posedge sys_clk) step <= 1'b0;
         cyc(130);
      end
   endtask
   task automatic put_gray(input logic [9:0] v);
      @(posedge sys_clk) gray_in <= v ^ (v >> 1);
      cyc(10);
   endtask
   task automatic pin_pre;
      @(posedge sys_clk) preload_pin <= 1'b1;
      cyc(150);
      @(posedge sys_clk) preload_pin <= 1'b0;
      cyc(150);
   endtask

   // ----
   // scenarios
   // ----
   task automatic t_quad;
      cyc(10);
      chk({status_bit_image[31:24], point_out_en}, {8'h68, 4'h0});
      steps(12, 1'b1);
      chk(position, 16'h0001);
      @(posedge sys_clk) reverse_dir <= 1'b1;
      steps(2, 1'b1);
      chk(position, 16'h000a);
      @(posedge sys_clk) {reverse_dir, fast_filter} <= 2'h0;
      steps(1, 1'b1);
      chk(position, 16'h000a);
      cyc(1000);
      chk(position, 16'h0000);
      @(posedge sys_clk) fast_filter <= 1'b1;
      $display("quadrature count test done");
   endtask
   task automatic t_load;
      @(posedge sys_clk) cmd.preload <= 1'b1;
      @(posedge sys_clk) cmd.preload <= 1'b0;
      cyc(5);
      chk({status_bit_image[25], position}, {1'b0, 16'h0007});
      steps(1, 1'b1);
      pin_pre();
      chk({status_bit_image[25], position}, {1'b1, 16'h0007});
      steps(1, 1'b1);
      pin_pre();
      chk(position, 16'h0008);
      @(posedge sys_clk) cmd.reset_preload <= 1'b1;
      @(posedge sys_clk) cmd.reset_preload <= 1'b0;
      cyc(5);
      chk(status_bit_image[25], 1'b0);
      @(posedge sys_clk) {home_switch_pin, cmd.home_start} <= 2'h3;
      cyc(20);
      @(posedge sys_clk) marker_pin <= 1'b1;
      cyc(150);
      @(posedge sys_clk) {marker_pin, cmd.home_start} <= 2'h0;
      cyc(10);
      chk({status_bit_image[26:24], position}, {3'h5, 16'h0003});
      $display("preload and home test done");
   endtask
   task automatic t_strobe_err;
      @(posedge sys_clk) point_in <= 4'h8;
      cyc(10);
      chk({caps[3:0], status_bit_image[23], status_bit_image[19]}, 6'h07);
      @(posedge sys_clk) point_in <= 4'h0;
      cyc(10);
      @(posedge sys_clk) point_in <= 4'h8;
      cyc(10);
      chk(caps[3:0], 4'h1);
      @(posedge sys_clk) cmd.reset_strobe <= 4'h8;
      cyc(3);
      @(posedge sys_clk) {bad_data_cmd, cmd.reset_strobe} <= 5'h10;
      @(posedge sys_clk) bad_data_cmd <= 1'b0;
      cyc(30);
      chk(status_bit_image[31], 1'b1);
      chk(status_bit_image[23], 1'b0);
      @(posedge sys_clk) cmd.clear_error <= ~cmd.clear_error;
      cyc(8);
      chk(status_bit_image[31], 1'b0);
      $display("strobe and error test done");
   endtask
   task automatic t_gray;
      @(posedge sys_clk) mode <= epc_pkg::GRAY_8BIT_MODE;
      put_gray(10'h0c8);
      chk(position, 16'h00c8);
      @(posedge sys_clk) reverse_dir <= 1'b1;
      cyc(10);
      chk(position, 16'h0037);
      @(posedge sys_clk) {reverse_dir, position_offset} <= {1'b0, 16'h000a};
      put_gray(10'h0fa);
      chk(position, 16'h0004);
      @(posedge sys_clk) position_offset <= 16'h0000;
      @(posedge sys_clk) mode <= epc_pkg::GRAY_10BIT_MODE;
      put_gray(10'h3e8);
      chk(position, 16'h03e8);
      chk({status_bit_image[4], point_out}, {1'b1, 4'h0});
      @(posedge sys_clk) mode <= epc_pkg::GRAY_EXCESS_MODE;
      put_gray(10'h1b3);
      chk(position, 16'h0167);
      chk({status_bit_image[4], point_out}, {1'b1, 4'h0});
      put_gray(10'h04c);
      chk(position, 16'h0000);
      $display("gray decode test done");
   endtask
   task automatic t_cmp;
      @(posedge sys_clk) mode <= epc_pkg::GRAY_8BIT_MODE;
      put_gray(10'h002);
      chk(status_bit_image[1:0], 2'h0);
      put_gray(10'h005);
      chk(status_bit_image[1:0], 2'h3);
      chk(point_out, 4'h1);
      cyc(30);
      chk(status_bit_image[1:0], 2'h1);
      put_gray(10'h003);
      chk(status_bit_image[1:0], 2'h1);
      put_gray(10'h002);
      chk(status_bit_image[1:0], 2'h0);
      $display("comparator test done");
   endtask

   initial begin
      foreach (cmp_cfg[i]) cmp_cfg[i] = {1'b0, 16'h00ff, 16'h0000, 16'h0000, 16'h0000};
      cmp_cfg[0] = {1'b0, 16'h0005, 16'h0002, 16'h0000, 16'h0000};
      cmp_cfg[1] = {1'b1, 16'h0005, 16'h0002, 16'h0002, 16'h0000};
      cmp_cfg[4] = {1'b0, 16'h03e8, 16'h00c8, 16'h0000, 16'h0000};
      cyc(1);
      @(posedge sys_clk) reset_n <= 1'b1;
      t_quad();
      t_load();
      t_strobe_err();
      t_gray();
      t_cmp();
      conclude();
   end
endmodule
